// [rtl/pe_regs_pkg.sv]
`default_nettype none
package pe_regs_pkg;

    // =========================================================
    // data file geometry
    localparam int DATA_W = 40;
    localparam int NUM_DATA_REGS = 16;
    localparam int IDX_W = 4;
    localparam int NARROW_SHIFT = 8;

    // =========================================================
    // sticky status bit positions
    localparam int STKY_MULT_INVALID = 9;
    localparam int STKY_MULT_UNDERFLOW = 8;
    localparam int STKY_MULT_OVERFLOW = 7;
    localparam int STKY_MULT_FIXED_OVF = 6;
    localparam int STKY_ALU_INVALID = 5;
    localparam int STKY_ALU_OVERFLOW_A = 2;
    localparam int STKY_ALU_OVERFLOW_B = 1;
    localparam int STKY_ALU_UNDERFLOW = 0;
    localparam logic [31:0] STKY_IMPL_MASK = 32'h0000_03e7;

    // =========================================================
    // values after reset
    localparam logic [31:0] STKY_RESET = 32'h0000_0000;
    localparam logic [31:0] TCOUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] TPERIOD_RESET = 32'h0000_0000;
    localparam logic [31:0] USTAT_RESET = 32'h0000_0000;
    localparam logic [39:0] DATA_RESET = 40'h00_0000_0000;

    // =========================================================
    // register access port
    typedef enum logic [2:0] {
        tgt_sticky,
        tgt_data,
        tgt_tcount,
        tgt_tperiod,
        tgt_ustat1,
        tgt_ustat2
    } ureg_target_t;

    typedef enum logic [2:0] {
        op_read,
        op_write,
        op_set,
        op_clear,
        op_toggle,
        op_test
    } ureg_op_t;

    typedef struct packed {
        logic valid;
        ureg_op_t op;
        ureg_target_t target;
        logic [IDX_W-1:0] index;
        logic alias_float;
        logic wide;
        logic [DATA_W-1:0] wdata;
    } ureg_req_t;

    typedef struct packed {
        logic valid;
        logic test_true;
        logic [DATA_W-1:0] rdata;
    } ureg_rsp_t;

    // =========================================================
    // computation unit side
    typedef struct packed {
        logic done;
        logic invalid;
        logic overflow;
    } alu_event_t;

    typedef struct packed {
        logic done;
        logic invalid;
        logic underflow;
        logic overflow;
        logic fixed_point;
    } mult_event_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] index;
        logic alias_float;
    } operand_req_t;

    typedef struct packed {
        logic valid;
        logic is_float;
        logic [DATA_W-1:0] data;
    } operand_rsp_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] index;
        logic [DATA_W-1:0] data;
    } result_wr_t;

endpackage : pe_regs_pkg
`default_nettype wire

// [rtl/pe_data_file.sv]
`default_nettype none
module pe_data_file #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16,
    parameter int IDX_W = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wa_en,
    input wire logic [IDX_W-1:0] wa_idx,
    input wire logic [WIDTH-1:0] wa_data,
    input wire logic wb_en,
    input wire logic [IDX_W-1:0] wb_idx,
    input wire logic [WIDTH-1:0] wb_data,
    input wire logic [IDX_W-1:0] ra_idx,
    output logic [WIDTH-1:0] ra_data,
    input wire logic [IDX_W-1:0] rb_idx,
    output logic [WIDTH-1:0] rb_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0] out_a;
        logic [WIDTH-1:0] out_b;
    } mem_state_t;

    mem_state_t st;
    mem_state_t next_st;

    // =========================================================
    // port b wins on the same index
    always_comb begin
        next_st = st;
        next_st.out_a = st.cells[ra_idx];
        next_st.out_b = st.cells[rb_idx];
        if (wa_en) begin
            next_st.cells[wa_idx] = wa_data;
        end
        if (wb_en) begin
            next_st.cells[wb_idx] = wb_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ra_data = st.out_a;
    assign rb_data = st.out_b;

endmodule : pe_data_file
`default_nettype wire

// [rtl/pe_sticky_timer_user_regs.sv]
// Contract
// - Sticky bit 9 is set and held when the multiplier reports invalid.
// - Sticky bit 8 is set and held when the multiplier reports underflow.
// - Sticky bit 7 is set and held when the multiplier reports overflow.
// - Sticky bit 6 is set and held on a fixed-point multiplier overflow.
// - Sticky bit 5 is set and held when the ALU reports invalid.
// - Sticky bits 2 and 1 are both set and held on an ALU overflow.
// - Sticky bit 0 latches the primary element's ALU zero/underflow flag.
// - There are sixteen 40-bit data registers, all bits read and write.
// - The data registers carry operands to and results from the units.
// - Both aliases of an index reach one register; width is not aliased.
// - The alias used tells the unit fixed or float treatment.
// - A 32-bit timer count reads, writes and decrements every cycle that timer_run is high and no program write takes it, reloading from the period at zero.
// - A 32-bit timer period reads and writes and sets the interval.
// - Two 32-bit user registers support write, set, clear and test.
// - A sticky bit stays set after its cause ends until a program clears it.
// - The plain ALU invalid flag clears on the next valid ALU operation.
`default_nettype none
module pe_sticky_timer_user_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire pe_regs_pkg::ureg_req_t ureg_req,
    output pe_regs_pkg::ureg_rsp_t ureg_rsp,
    input wire pe_regs_pkg::alu_event_t alu_event,
    input wire pe_regs_pkg::mult_event_t mult_event,
    input wire logic primary_alu_zero_underflow,
    input wire pe_regs_pkg::operand_req_t operand_req,
    output pe_regs_pkg::operand_rsp_t operand_rsp,
    input wire pe_regs_pkg::result_wr_t result_wr,
    input wire logic timer_run,
    output logic timer_irq,
    output logic alu_invalid_flag,
    output logic [31:0] sticky_status_secondary
);
    import pe_regs_pkg::*;

    typedef struct packed {
        logic valid;
        ureg_target_t target;
        logic wide;
        logic test;
        logic [31:0] mask;
        logic [31:0] value;
    } pipe_t;

    typedef struct packed {
        logic [31:0] sticky;
        logic [31:0] tcount;
        logic [31:0] tperiod;
        logic [31:0] ustat1;
        logic [31:0] ustat2;
        logic alu_invalid;
        logic timer_irq;
        pipe_t p1;
        ureg_rsp_t rsp;
        logic opnd_p1_valid;
        logic opnd_p1_float;
        operand_rsp_t opnd_rsp;
    } state_t;

    state_t st;
    state_t next_st;

    logic [DATA_W-1:0] mem_ureg_data;
    logic [DATA_W-1:0] mem_opnd_data;
    logic data_wr_en;
    logic [DATA_W-1:0] data_wr_val;
    logic modify;
    logic [31:0] cur32;
    logic [31:0] mod32;
    logic [31:0] set_bits;

    // =========================================================
    // data register file
    assign data_wr_en = ureg_req.valid && ureg_req.target == tgt_data &&
                        ureg_req.op == op_write;
    // narrow transfers occupy the upper 32 bits
    assign data_wr_val = ureg_req.wide ? ureg_req.wdata :
        {ureg_req.wdata[31:0], {NARROW_SHIFT{1'b0}}};

    pe_data_file #(
        .WIDTH(DATA_W),
        .DEPTH(NUM_DATA_REGS),
        .IDX_W(IDX_W)
    ) u_data_file (
        .core_clk(core_clk),
        .rst(rst),
        .wa_en(data_wr_en),
        .wa_idx(ureg_req.index),
        .wa_data(data_wr_val),
        .wb_en(result_wr.valid),
        .wb_idx(result_wr.index),
        .wb_data(result_wr.data),
        .ra_idx(ureg_req.index),
        .ra_data(mem_ureg_data),
        .rb_idx(operand_req.index),
        .rb_data(mem_opnd_data)
    );

    // =========================================================
    // next state
    always_comb begin
        next_st = st;
        case (ureg_req.target)
            tgt_sticky: cur32 = st.sticky;
            tgt_tcount: cur32 = st.tcount;
            tgt_tperiod: cur32 = st.tperiod;
            tgt_ustat1: cur32 = st.ustat1;
            tgt_ustat2: cur32 = st.ustat2;
            default: cur32 = 32'h0000_0000;
        endcase
        // bit-wise operations
        case (ureg_req.op)
            op_write: mod32 = ureg_req.wdata[31:0];
            op_set: mod32 = cur32 | ureg_req.wdata[31:0];
            op_clear: mod32 = cur32 & ~ureg_req.wdata[31:0];
            op_toggle: mod32 = cur32 ^ ureg_req.wdata[31:0];
            default: mod32 = cur32;
        endcase
        modify = ureg_req.valid && ureg_req.op != op_read &&
                 ureg_req.op != op_test && ureg_req.target != tgt_data;

        // sticky sources
        set_bits = 32'h0000_0000;
        if (mult_event.done) begin
            set_bits[STKY_MULT_INVALID] = mult_event.invalid;
            set_bits[STKY_MULT_UNDERFLOW] = mult_event.underflow;
            set_bits[STKY_MULT_OVERFLOW] = mult_event.overflow;
            set_bits[STKY_MULT_FIXED_OVF] = mult_event.overflow &&
                                            mult_event.fixed_point;
        end
        if (alu_event.done) begin
            set_bits[STKY_ALU_INVALID] = alu_event.invalid;
            set_bits[STKY_ALU_OVERFLOW_A] = alu_event.overflow;
            set_bits[STKY_ALU_OVERFLOW_B] = alu_event.overflow;
        end
        set_bits[STKY_ALU_UNDERFLOW] = primary_alu_zero_underflow;

        // set beats a program clear in the same cycle
        if (modify && ureg_req.target == tgt_sticky) begin
            next_st.sticky = (mod32 | set_bits) & STKY_IMPL_MASK;
        end else begin
            next_st.sticky = (st.sticky | set_bits) & STKY_IMPL_MASK;
        end

        if (modify && ureg_req.target == tgt_tperiod) begin
            next_st.tperiod = mod32;
        end
        if (modify && ureg_req.target == tgt_ustat1) begin
            next_st.ustat1 = mod32;
        end
        if (modify && ureg_req.target == tgt_ustat2) begin
            next_st.ustat2 = mod32;
        end

        // timer: a program write overrides the count
        next_st.timer_irq = 1'b0;
        if (modify && ureg_req.target == tgt_tcount) begin
            next_st.tcount = mod32;
        end else if (timer_run) begin
            if (st.tcount == 32'h0000_0000) begin
                next_st.timer_irq = 1'b1;
                next_st.tcount = st.tperiod;
            end else begin
                next_st.tcount = st.tcount - 32'h0000_0001;
            end
        end

        // non-sticky flag follows the latest ALU operation
        if (alu_event.done) begin
            next_st.alu_invalid = alu_event.invalid;
        end

        // register access answer, two cycles after the request
        next_st.p1.valid = ureg_req.valid;
        next_st.p1.target = ureg_req.target;
        next_st.p1.wide = ureg_req.wide;
        next_st.p1.test = ureg_req.op == op_test;
        next_st.p1.mask = ureg_req.wdata[31:0];
        next_st.p1.value = cur32;
        next_st.rsp.valid = st.p1.valid;
        next_st.rsp.test_true = st.p1.test &&
            st.p1.target != tgt_data &&
            ((st.p1.value & st.p1.mask) == st.p1.mask);
        if (st.p1.target == tgt_data) begin
            next_st.rsp.rdata = st.p1.wide ? mem_ureg_data :
                {{NARROW_SHIFT{1'b0}},
                 mem_ureg_data[DATA_W-1:NARROW_SHIFT]};
        end else begin
            next_st.rsp.rdata = {{NARROW_SHIFT{1'b0}}, st.p1.value};
        end

        // operand fetch for the units
        next_st.opnd_p1_valid = operand_req.valid;
        next_st.opnd_p1_float = operand_req.alias_float;
        next_st.opnd_rsp.valid = st.opnd_p1_valid;
        next_st.opnd_rsp.is_float = st.opnd_p1_float;
        next_st.opnd_rsp.data = mem_opnd_data;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.sticky <= STKY_RESET;
            st.tcount <= TCOUNT_RESET;
            st.tperiod <= TPERIOD_RESET;
            st.ustat1 <= USTAT_RESET;
            st.ustat2 <= USTAT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ureg_rsp = st.rsp;
    assign operand_rsp = st.opnd_rsp;
    assign timer_irq = st.timer_irq;
    assign alu_invalid_flag = st.alu_invalid;
    assign sticky_status_secondary = st.sticky;

    // =========================================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic sticky_touched;
    logic tcount_touched;
    assign sticky_touched = modify && ureg_req.target == tgt_sticky;
    assign tcount_touched = modify && ureg_req.target == tgt_tcount;

    AST_MULT_INVALID: assert property (
        mult_event.done && mult_event.invalid |=> sticky_status_secondary[9]
    ) else $error("multiplier invalid not latched");
    AST_MULT_UNDERFLOW: assert property (
        mult_event.done && mult_event.underflow
        |=> sticky_status_secondary[8]
    ) else $error("multiplier underflow not latched");
    AST_MULT_OVERFLOW: assert property (
        mult_event.done && mult_event.overflow |=> sticky_status_secondary[7]
    ) else $error("multiplier overflow not latched");
    AST_MULT_FIXED_OVF: assert property (
        mult_event.done && mult_event.overflow && mult_event.fixed_point
        |=> sticky_status_secondary[6]
    ) else $error("fixed-point overflow not latched");
    AST_ALU_INVALID: assert property (
        alu_event.done && alu_event.invalid |=> sticky_status_secondary[5]
    ) else $error("alu invalid not latched");
    AST_ALU_OVERFLOW: assert property (
        alu_event.done && alu_event.overflow
        |=> sticky_status_secondary[2] && sticky_status_secondary[1]
    ) else $error("alu overflow pair not latched");
    AST_ALU_UNDERFLOW: assert property (
        primary_alu_zero_underflow |=> sticky_status_secondary[0]
    ) else $error("alu underflow not latched");
    AST_STICKY_HOLDS: assert property (
        !sticky_touched [*1] ##1 !sticky_touched
        |-> (sticky_status_secondary & $past(sticky_status_secondary))
            == $past(sticky_status_secondary)
    ) else $error("sticky bit dropped without a program write");
    AST_PLAIN_INVALID_CLEARS: assert property (
        alu_event.done && !alu_event.invalid
        |=> !alu_invalid_flag ##0 sticky_status_secondary[5]
            == $past(sticky_touched ? mod32[5] :
                     sticky_status_secondary[5])
    ) else $error("plain alu invalid flag not cleared");
    AST_TIMER_DECREMENT: assert property (
        timer_run && !tcount_touched && st.tcount != 32'h0000_0000
        |=> st.tcount == $past(st.tcount) - 32'h0000_0001 && !timer_irq
    ) else $error("timer count did not decrement");
    AST_TIMER_RELOAD: assert property (
        timer_run && !tcount_touched && st.tcount == 32'h0000_0000
        |=> timer_irq && st.tcount == $past(st.tperiod)
    ) else $error("timer did not fire and reload");
    AST_PERIOD_WRITE: assert property (
        modify && ureg_req.target == tgt_tperiod && ureg_req.op == op_write
        |=> st.tperiod == $past(ureg_req.wdata[31:0])
    ) else $error("timer period write lost");
    AST_USER_SET: assert property (
        modify && ureg_req.target == tgt_ustat1 && ureg_req.op == op_set
        |=> (st.ustat1 & $past(ureg_req.wdata[31:0]))
            == $past(ureg_req.wdata[31:0])
    ) else $error("user flag set failed");
    AST_OPERAND_ALIAS: assert property (
        operand_req.valid
        |-> ##2 operand_rsp.valid && operand_rsp.is_float
            == $past(operand_req.alias_float, 2)
    ) else $error("operand alias or timing wrong");
    AST_DATA_ROUNDTRIP: assert property (
        data_wr_en && ureg_req.wide && !(result_wr.valid &&
            result_wr.index == ureg_req.index)
        ##1 (ureg_req.valid && ureg_req.target == tgt_data &&
             ureg_req.op == op_read && ureg_req.wide &&
             ureg_req.index == $past(ureg_req.index))
        |-> ##2 ureg_rsp.valid && ureg_rsp.rdata == $past(ureg_req.wdata, 3)
    ) else $error("data register did not return written value");

    COV_TIMER_FIRE: cover property (timer_run ##1 timer_irq);
    COV_STICKY_SET_CLEAR: cover property (
        sticky_touched && ureg_req.op == op_clear && |set_bits);
    COV_TEST_TRUE: cover property (ureg_rsp.valid && ureg_rsp.test_true);
    COV_FLOAT_OPERAND: cover property (
        operand_rsp.valid && operand_rsp.is_float);

endmodule : pe_sticky_timer_user_regs
`default_nettype wire

// [sim/test_pe_sticky_timer_user_regs.sv]
`default_nettype none
module test_pe_sticky_timer_user_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pe_regs_pkg::*;

    logic core_clk;
    logic rst;
    ureg_req_t ureg_req;
    ureg_rsp_t ureg_rsp;
    alu_event_t alu_event;
    mult_event_t mult_event;
    logic primary_alu_zero_underflow;
    operand_req_t operand_req;
    operand_rsp_t operand_rsp;
    result_wr_t result_wr;
    logic timer_run;
    logic timer_irq;
    logic alu_invalid_flag;
    logic [31:0] sticky_status_secondary;
    int error_cnt;
    int compares;
    logic [31:0] seed;
    logic [31:0] exp_sticky;
    logic exp_ai;
    logic [39:0] shadow [16];
    ureg_rsp_t rsp;

    pe_sticky_timer_user_regs i_pe_sticky_timer_user_regs (
        .core_clk(core_clk),
        .rst(rst),
        .ureg_req(ureg_req),
        .ureg_rsp(ureg_rsp),
        .alu_event(alu_event),
        .mult_event(mult_event),
        .primary_alu_zero_underflow(primary_alu_zero_underflow),
        .operand_req(operand_req),
        .operand_rsp(operand_rsp),
        .result_wr(result_wr),
        .timer_run(timer_run),
        .timer_irq(timer_irq),
        .alu_invalid_flag(alu_invalid_flag),
        .sticky_status_secondary(sticky_status_secondary)
    );

    initial begin
        core_clk = 1'b0;
        forever begin
            #2 core_clk = ~core_clk;
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] sticky_sets(input alu_event_t a,
            input mult_event_t m, input logic p);
        logic [31:0] s;
        s = 32'h0;
        s[9] = m.done & m.invalid;
        s[8] = m.done & m.underflow;
        s[7] = m.done & m.overflow;
        s[6] = m.done & m.overflow & m.fixed_point;
        s[5] = a.done & a.invalid;
        s[2] = a.done & a.overflow;
        s[1] = a.done & a.overflow;
        s[0] = p;
        return s;
    endfunction : sticky_sets

    function automatic logic [31:0] apply(input ureg_op_t op,
            input logic [31:0] v, input logic [31:0] m);
        case (op)
            op_set: return v | m;
            op_clear: return v & ~m;
            op_toggle: return v ^ m;
            default: return v;
        endcase
    endfunction : apply

    task automatic summarize();
        $display("checks %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic check_val(input string what, input logic [39:0] exp,
            input logic [39:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_bit(input string what, input logic exp,
            input logic got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic access(input ureg_op_t op, input ureg_target_t tg,
            input logic [3:0] idx, input logic wide, input logic [39:0] wd);
        logic [31:0] r;
        r = rnd();
        @(negedge core_clk);
        ureg_req = '{1'b1, op, tg, idx, r[0], wide, wd};
        @(negedge core_clk);
        ureg_req.valid = 1'b0;
        @(negedge core_clk);
        rsp = ureg_rsp;
        check_bit("ureg_rsp.valid", 1'b1, rsp.valid);
    endtask : access

    task automatic fire(input alu_event_t a, input mult_event_t m,
            input logic p);
        @(negedge core_clk);
        alu_event = a;
        mult_event = m;
        primary_alu_zero_underflow = p;
        @(negedge core_clk);
        alu_event = '0;
        mult_event = '0;
        primary_alu_zero_underflow = 1'b0;
        exp_sticky = exp_sticky | sticky_sets(a, m, p);
        if (a.done) begin
            exp_ai = a.invalid;
        end
        check_val("sticky", {8'h00, exp_sticky}, {8'h00, sticky_status_secondary});
        check_bit("alu_invalid_flag", exp_ai, alu_invalid_flag);
    endtask : fire

    task automatic operand(input logic [3:0] idx, input logic fl);
        @(negedge core_clk);
        operand_req = '{1'b1, idx, fl};
        @(negedge core_clk);
        operand_req.valid = 1'b0;
        @(negedge core_clk);
        check_bit("operand_rsp.valid", 1'b1, operand_rsp.valid);
        check_val("operand_rsp.data", shadow[idx], operand_rsp.data);
        check_bit("operand_rsp.is_float", fl, operand_rsp.is_float);
    endtask : operand

    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (timer_irq !== 1'b1 && n < 200);
        if (n >= 200) begin
            error_cnt++;
            $display("ERROR timer_irq expected 1 seen 0");
            summarize();
        end
    endtask : wait_irq

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] v, m, p, k, r;
        logic [8:0] ev;
        logic [39:0] d;
        alu_event_t a;
        mult_event_t me;
        logic pz;
        ureg_op_t op;
        int n;
        logic [31:0] rv [6];
        logic [8:0] ev_tab [8];
        ureg_op_t ops [4];
        ev_tab = '{9'b0_000_11000, 9'b0_000_10100, 9'b0_000_10010,
            9'b0_000_10011, 9'b0_110_00000, 9'b0_101_00000,
            9'b1_000_00000, 9'b0_011_01111};
        ops = '{op_set, op_clear, op_toggle, op_test};
        rv = '{STKY_RESET, 32'h0, TCOUNT_RESET, TPERIOD_RESET,
            USTAT_RESET, USTAT_RESET};
        seed = 32'h296c;
        error_cnt = 0;
        compares = 0;
        rst = 1'b1;
        ureg_req = '0;
        alu_event = '0;
        mult_event = '0;
        primary_alu_zero_underflow = 1'b0;
        operand_req = '0;
        result_wr = '0;
        timer_run = 1'b0;
        exp_sticky = 32'h0;
        exp_ai = 1'b0;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        for (int t = 0; t < 6; t++) begin
            access(op_read, ureg_target_t'(t), 4'h0, t == 1, 40'h0);
            check_val("reset value", t == 1 ? DATA_RESET : {8'h00, rv[t]}, rsp.rdata);
        end
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            access(op_write, tgt_sticky, 4'h0, 1'b0, 40'h0);
            exp_sticky = 32'h0;
            {pz, a, me} = ev_tab[i];
            fire(a, me, pz);
            repeat (3) @(negedge core_clk);
            check_val("sticky held", {8'h00, exp_sticky}, {8'h00, sticky_status_secondary});
            access(op_clear, tgt_sticky, 4'h0, 1'b0, {8'h00, exp_sticky});
            exp_sticky = 32'h0;
            check_val("sticky cleared", 40'h0, {8'h00, sticky_status_secondary});
        end
        for (int i = 0; i < 30; i++) begin
            r = rnd();
            fire(r[2:0], r[7:3], r[8] & r[9]);
        end
        access(op_read, tgt_sticky, 4'h0, 1'b0, 40'h0);
        check_val("sticky read", {8'h00, exp_sticky}, rsp.rdata);
        v = rnd();
        access(op_write, tgt_sticky, 4'h0, 1'b0, {8'h00, v});
        access(op_read, tgt_sticky, 4'h0, 1'b0, 40'h0);
        check_val("sticky write", {8'h00, v & STKY_IMPL_MASK}, rsp.rdata);
        $display("test sticky done");
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            shadow[i] = {r[7:0], rnd()};
            access(op_write, tgt_data, i[3:0], 1'b1, shadow[i]);
        end
        for (int i = 0; i < 16; i++) begin
            access(op_read, tgt_data, i[3:0], 1'b1, 40'h0);
            check_val("data wide", shadow[i], rsp.rdata);
            access(op_read, tgt_data, i[3:0], 1'b0, 40'h0);
            check_val("data narrow", {8'h00, shadow[i][39:8]}, rsp.rdata);
        end
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            v = rnd();
            access(op_write, tgt_data, r[3:0], 1'b0, {r[15:8], v});
            shadow[r[3:0]] = {v, 8'h00};
            access(op_test, tgt_data, r[3:0], 1'b1, 40'hff_ffff_ffff);
            check_val("data after narrow write", shadow[r[3:0]], rsp.rdata);
            check_bit("data test", 1'b0, rsp.test_true);
            d = {r[23:16], rnd()};
            @(negedge core_clk);
            result_wr = '{1'b1, r[27:24], d};
            @(negedge core_clk);
            result_wr.valid = 1'b0;
            shadow[r[27:24]] = d;
            operand(r[27:24], r[28]);
            operand(r[31:28], r[29]);
        end
        // write then read of one index on consecutive edges
        d = {r[7:0], rnd()};
        @(negedge core_clk);
        ureg_req = '{1'b1, op_write, tgt_data, 4'h5, 1'b0, 1'b1, d};
        @(negedge core_clk);
        ureg_req.op = op_read;
        shadow[5] = d;
        @(negedge core_clk);
        ureg_req.valid = 1'b0;
        @(negedge core_clk);
        check_bit("ureg_rsp.valid", 1'b1, ureg_rsp.valid);
        check_val("data back to back", d, ureg_rsp.rdata);
        $display("test data done");
        for (int j = 0; j < 2; j++) begin
            v = rnd();
            access(op_write, j ? tgt_ustat2 : tgt_ustat1, 4'h0, 1'b0, {8'h00, v});
            for (int i = 0; i < 16; i++) begin
                op = ops[i % 4];
                m = (i % 8 < 4) ? rnd() : (v & rnd());
                access(op, j ? tgt_ustat2 : tgt_ustat1, 4'h0, 1'b0, {8'h00, m});
                check_val("ustat", {8'h00, v}, rsp.rdata);
                if (op == op_test) begin
                    check_bit("ustat test", (v & m) == m, rsp.test_true);
                end
                v = apply(op, v, m);
            end
        end
        $display("test user done");
        p = 32'd3 + (rnd() % 8);
        access(op_write, tgt_tperiod, 4'h0, 1'b0, {8'h00, p});
        access(op_read, tgt_tperiod, 4'h0, 1'b0, 40'h0);
        check_val("tperiod", {8'h00, p}, rsp.rdata);
        v = 32'd1000 + (rnd() % 1000);
        k = 32'd5 + (rnd() % 20);
        access(op_write, tgt_tcount, 4'h0, 1'b0, {8'h00, v});
        timer_run = 1'b1;
        repeat (k) @(negedge core_clk);
        timer_run = 1'b0;
        access(op_read, tgt_tcount, 4'h0, 1'b0, 40'h0);
        check_val("tcount", {8'h00, v - k}, rsp.rdata);
        access(op_write, tgt_tcount, 4'h0, 1'b0, 40'h0);
        timer_run = 1'b1;
        wait_irq(n);
        for (int i = 0; i < 2; i++) begin
            wait_irq(n);
            check_val("irq interval", {8'h00, p + 32'd1}, {8'h00, n[31:0]});
        end
        timer_run = 1'b0;
        $display("test timer done");
        summarize();
    end
endmodule : test_pe_sticky_timer_user_regs
`default_nettype wire
